// [bench/mpcd_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mpcd_ctrl_model
   import mpcd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Command group outputs
   output logic [2:0] memory_cmd_code_o,
   output logic [3:0] pci_cmd_code_o,
   output logic pci_drive_enable_o,
   output logic trdy_b_o
);
   logic fill_open_ff = 1'b0;
   initial begin
      memory_cmd_code_o = MC_IDLE;
      pci_cmd_code_o = PC_RSVD;
      pci_drive_enable_o = 1'b0;
      trdy_b_o = 1'b1;
   end
   // One command pair per clock, changed just after the edge
   task automatic issue(input mpcd_mem_cmd_t m, input mpcd_pci_cmd_t p);
      @(posedge clk_i);
      memory_cmd_code_o <= m;
      pci_cmd_code_o <= p;
      if (m == MC_FILL_FIRST) begin
         fill_open_ff <= 1'b1;
      end
      if (m == MC_FILL_NEXT && !fill_open_ff) begin
         $display("unexpected fill_next before fill_first");
      end
   endtask
   task automatic enable(input logic e);
      @(posedge clk_i);
      pci_drive_enable_o <= e;
   endtask
   // Target ready, active low; changed just after the edge
   task automatic trdy(input logic t);
      @(posedge clk_i);
      trdy_b_o <= t;
   endtask
endmodule
`default_nettype wire

// [bench/mpcd_top_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module mpcd_top_tb_top
   import mpcd_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   wire logic [2:0] mem_cmd;
   wire logic [3:0] pci_cmd;
   wire logic drv_en;
   wire logic trdy_b;
   logic [63:0] mem_in = 64'h0;
   logic [63:0] mem_out;
   logic mem_oe;
   logic [31:0] ad_in = 32'h0;
   logic [31:0] ad_out;
   logic ad_oe, par, end_of_line_flag, hw_ready;
   logic [31:0] host_addr = 32'hCAFE_0010;
   logic hw_valid = 1'b0;
   logic [63:0] hw_data = 64'h0;
   logic cpw_push = 1'b0;
   logic [31:0] cpw_addr = 32'h0;
   logic [31:0] cpw_data = 32'h0;
   logic [1:0] pf_idx = 2'h0;
   logic [31:0] pf_data;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;

   always #5 clk_i = ~clk_i;

   mpcd_ctrl_model u_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .memory_cmd_code_o(mem_cmd),
      .pci_cmd_code_o(pci_cmd), .pci_drive_enable_o(drv_en), .trdy_b_o(trdy_b));

   mpcd_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .memory_cmd_code_i(mem_cmd),
      .pci_cmd_code_i(pci_cmd), .pci_drive_enable_i(drv_en), .trdy_b_i(trdy_b),
      .mem_data_i(mem_in), .mem_data_o(mem_out), .mem_data_oe_o(mem_oe),
      .pci_ad_i(ad_in), .pci_ad_o(ad_out), .pci_ad_oe_o(ad_oe), .pci_parity_out_o(par),
      .end_of_line_flag_o(end_of_line_flag), .host_addr_i(host_addr), .host_wr_valid_i(hw_valid),
      .host_wr_data_i(hw_data), .host_wr_ready_o(hw_ready), .cpw_push_i(cpw_push),
      .cpw_addr_i(cpw_addr), .cpw_data_i(cpw_data), .pf_rd_idx_i(pf_idx),
      .pf_rd_data_o(pf_data));

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Input changes need two edges to pass the pin synchronisers; three are allowed
   task automatic set_ad(input logic [31:0] v);
      @(posedge clk_i);
      ad_in <= v;
      wait_n(3);
   endtask
   // Issue one PCI drive command and look at the answer a clock later
   task automatic drv(input mpcd_pci_cmd_t p, input logic [31:0] exp);
      u_ctrl.issue(MC_IDLE, p);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      #1;
      chk("pci_ad_o", 64'(ad_out), 64'(exp));
      chk("pci_parity_out_o", 64'(par), 64'(^exp));
   endtask
   task automatic mem_retire(input mpcd_mem_cmd_t m);
      u_ctrl.issue(m, PC_RSVD);
      u_ctrl.issue(MC_HOLD_DRIVE, PC_RSVD);
      #1;
   endtask
   task automatic post(input logic [31:0] v);
      set_ad(v);
      u_ctrl.issue(MC_IDLE, PC_POST_DATA);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      #1;
      chk("received parity", 64'(par), 64'(^v));
   endtask

   task automatic t_host_write();
      @(posedge clk_i);
      hw_valid <= 1'b1;
      hw_data <= 64'hA1A1_0000_0000_0001;
      @(posedge clk_i) hw_data <= 64'hB2B2_0000_0000_0002;
      @(posedge clk_i) hw_data <= 64'hC3C3_0000_0000_0003;
      @(posedge clk_i) hw_valid <= 1'b0;
      #1 chk("host_wr_ready full", 64'(hw_ready), 64'h0);
      mem_retire(MC_RETIRE_HOST);
      chk("mem_data_o", mem_out, 64'hA1A1_0000_0000_0001);
      chk("mem_data_oe_o", 64'(mem_oe), 64'h1);
      u_ctrl.issue(MC_HOLD_DRIVE, PC_RSVD);
      #1 chk("held data", mem_out, 64'hA1A1_0000_0000_0001);
      u_ctrl.issue(MC_RSVD, PC_RSVD);
      u_ctrl.issue(MC_RETIRE_HOST, PC_RSVD);
      #1 chk("oe after reserved", 64'(mem_oe), 64'h0);
      u_ctrl.issue(MC_HOLD_DRIVE, PC_RSVD);
      #1 chk("second qword", mem_out, 64'hB2B2_0000_0000_0002);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      #1 chk("oe after idle", 64'(mem_oe), 64'h0);
      chk("host_wr_ready drained", 64'(hw_ready), 64'h1);
      $display("test host_write done");
   endtask

   task automatic t_read_path();
      @(posedge clk_i) mem_in <= 64'h0123_4567_89AB_CDEF;
      wait_n(3);
      u_ctrl.issue(MC_FILL_FIRST, PC_RSVD);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      mem_in <= 64'hFEDC_BA98_7654_3210;
      wait_n(3);
      u_ctrl.issue(MC_FILL_NEXT, PC_RSVD);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      u_ctrl.enable(1'b1);
      @(posedge clk_i);
      #1 chk("pci_ad_oe_o next clock", 64'(ad_oe), 64'h1);
      drv(PC_SEND_LOW, 32'h89AB_CDEF);
      chk("pci_ad_oe_o on", 64'(ad_oe), 64'h1);
      drv(PC_SEND_HIGH, 32'h0123_4567);
      drv(PC_SEND_LOW, 32'h89AB_CDEF);
      drv(PC_SEND_NEXT, 32'h0123_4567);
      drv(PC_SEND_NEXT, 32'h7654_3210);
      u_ctrl.enable(1'b0);
      @(posedge clk_i);
      #1 chk("pci_ad_oe_o off", 64'(ad_oe), 64'h0);
      $display("test read_path done");
   endtask

   task automatic t_prefetch();
      mpcd_pci_cmd_t seq [4] = '{PC_PF_FIRST, PC_PF_TOG_A, PC_PF_TOG_B, PC_PF_TOG_A};
      logic [31:0] d [4] = '{32'h1000_000A, 32'h2000_000B, 32'h3000_000C, 32'h4000_000D};
      for (int i = 0; i < 4; i++) begin
         u_ctrl.issue(MC_IDLE, seq[i]);
         ad_in <= d[i];
         repeat (4) u_ctrl.issue(MC_IDLE, seq[i]);
      end
      #1 chk("input parity", 64'(par), 64'(^d[3]));
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      ad_in <= 32'hDEAD_0000;
      wait_n(4);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) pf_idx <= 2'(i);
         wait_n(2);
         #1 chk("prefetch slot", 64'(pf_data), 64'(d[i]));
      end
      $display("test prefetch done");
   endtask

   task automatic t_cpu_write();
      @(posedge clk_i);
      cpw_push <= 1'b1;
      cpw_addr <= 32'hA000_0000;
      cpw_data <= 32'hD000_0000;
      @(posedge clk_i);
      cpw_addr <= 32'hA000_0004;
      cpw_data <= 32'hD000_0004;
      @(posedge clk_i) cpw_push <= 1'b0;
      u_ctrl.enable(1'b1);
      wait_n(3);
      drv(PC_DRV_WADDR, 32'hA000_0000);
      drv(PC_DRV_WDATA, 32'hD000_0000);
      drv(PC_DRV_WADDR, 32'hA000_0000);
      u_ctrl.trdy(1'b0);
      wait_n(3);
      drv(PC_DRV_WDATA, 32'hD000_0000);
      drv(PC_DRV_LAST, 32'hD000_0000);
      drv(PC_DRV_WADDR, 32'hA000_0004);
      u_ctrl.issue(MC_IDLE, PC_BACKUP);
      drv(PC_DRV_WADDR, 32'hA000_0000);
      u_ctrl.issue(MC_IDLE, PC_DISCARD);
      drv(PC_DRV_WADDR, 32'hA000_0004);
      drv(PC_SEND_HADDR, 32'hCAFE_0010);
      @(posedge clk_i) host_addr <= 32'h5A5A_0020;
      drv(PC_SEND_HADDR, 32'h5A5A_0020);
      u_ctrl.trdy(1'b1);
      u_ctrl.enable(1'b0);
      $display("test cpu_write done");
   endtask

   task automatic t_post_retire();
      set_ad(32'h0000_001C);
      u_ctrl.issue(MC_IDLE, PC_LATCH_MADDR);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      #1 chk("end_of_line_flag_o set", 64'(end_of_line_flag), 64'h1);
      set_ad(32'h0000_000C);
      u_ctrl.issue(MC_IDLE, PC_LATCH_MADDR);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      #1 chk("end_of_line_flag_o clear", 64'(end_of_line_flag), 64'h0);
      u_ctrl.issue(MC_IDLE, PC_POST_ADDR);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      post(32'hE000_0000);
      post(32'hE111_1111);
      mem_retire(MC_RETIRE_PCI);
      chk("retire pci", mem_out, 64'hE111_1111_E000_0000);
      u_ctrl.issue(MC_IDLE, PC_POST_ADDR);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      post(32'hF000_0000);
      post(32'hF111_1111);
      mem_retire(MC_RETIRE_SHIFT);
      chk("shifted high dword", 64'(mem_out[63:32]), 64'hF000_0000);
      mem_retire(MC_RETIRE_SHIFT);
      chk("shifted low dword", 64'(mem_out[31:0]), 64'hF111_1111);
      u_ctrl.issue(MC_IDLE, PC_RSVD);
      $display("test post_retire done");
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      wait_n(4);
      rst_b_i <= 1'b1;
      #1 chk("mem_data_oe_o reset", 64'(mem_oe), 64'h0);
      chk("pci_ad_oe_o reset", 64'(ad_oe), 64'h0);
      chk("end_of_line_flag_o reset", 64'(end_of_line_flag), 64'h0);
      t_host_write();
      t_read_path();
      t_prefetch();
      t_cpu_write();
      t_post_retire();
      final_report();
   end
endmodule
`default_nettype wire

// [hdl/mpcd_pkg.sv]
package mpcd_pkg;
   // Memory command group
   typedef enum logic [2:0] {
      MC_IDLE = 3'b000,
      MC_FILL_FIRST = 3'b001,
      MC_FILL_NEXT = 3'b010,
      MC_RSVD = 3'b011,
      MC_RETIRE_HOST = 3'b100,
      MC_RETIRE_PCI = 3'b101,
      MC_RETIRE_SHIFT = 3'b110,
      MC_HOLD_DRIVE = 3'b111
   } mpcd_mem_cmd_t;

   // PCI command group
   typedef enum logic [3:0] {
      PC_PF_FIRST = 4'b0000,
      PC_PF_TOG_A = 4'b0001,
      PC_PF_TOG_B = 4'b0010,
      PC_LATCH_MADDR = 4'b0011,
      PC_DRV_WADDR = 4'b0100,
      PC_DRV_WDATA = 4'b0101,
      PC_DRV_LAST = 4'b0110,
      PC_SEND_HADDR = 4'b0111,
      PC_POST_ADDR = 4'b1000,
      PC_POST_DATA = 4'b1001,
      PC_BACKUP = 4'b1010,
      PC_DISCARD = 4'b1011,
      PC_SEND_LOW = 4'b1100,
      PC_SEND_HIGH = 4'b1101,
      PC_SEND_NEXT = 4'b1110,
      PC_RSVD = 4'b1111
   } mpcd_pci_cmd_t;

   // Buffer geometry
   localparam int unsigned RD_QWORDS = 4;
   localparam int unsigned LINE_DWORDS = 8;
   localparam int unsigned PMW_DWORDS = 4;
   localparam int unsigned CPW_ENTRIES = 4;
   localparam int unsigned PF_DWORDS = 4;
   localparam logic [3:0] EOL_RST = 4'h8;
   localparam logic [63:0] QWORD_RST = 64'h0;
   localparam logic [31:0] DWORD_RST = 32'h0;
endpackage

// [hdl/mpcd_skid.sv]
`timescale 1ns/10ps
`default_nettype none
// Two-entry buffer on the host-write qword path toward the retire logic
module mpcd_skid
   import mpcd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [63:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [63:0] out_data_o
);
   logic [63:0] mem_ff [2];
   logic wp_ff;
   logic rp_ff;
   logic [1:0] cnt_ff;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   logic [1:0] nxt_cnt;
   logic ready_ff;

   assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   // Ready is registered so that the top-level port comes from a flip-flop
   assign in_ready_o = ready_ff;
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o = mem_ff[rp_ff];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
         ready_ff <= 1'b0;
      end else begin
         if (push) wp_ff <= ~wp_ff;
         if (pop) rp_ff <= ~rp_ff;
         cnt_ff <= nxt_cnt;
         ready_ff <= (nxt_cnt != 2'h2);
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) mem_ff[wp_ff] <= in_data_i;
   end

   no_overflow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cnt_ff <= 2'h2) else $error("Buffer count exceeds two");
endmodule
`default_nettype wire

// [hdl/mpcd_top.sv]
// Functional notes
// - Idle memory command releases memory bus
// - Fill-first stores qword at read-buffer slot zero
// - Fill-next stores qword at next read slot
// - Retire-host outputs one posted host qword
// - Retire-PCI outputs qword, switches buffer after line's last qword
// - Shifted retire moves data up one dword
// - Retires latch data; hold-drive keeps driving
// - Drive PCI lines only the clock after enable was high
// - Parity follows received or driven value
// - Post-address selects buffer, loads master address
// - Post-data writes latch into next location
// - Send high/low drive first qword half
// - Send-next drives next read dword
// - Latch-first captures into prefetch slot zero
// - Alternating toggles advance; repeat overwrites slot
// - Drive-address keeps write read pointer
// - Drive-data advances pointer next clock on TRDY
// - Drive-last repeats previous data dword
// - Discard drops current write entry
// - Backup steps write buffer back one entry
// - Send-host-address drives host address
// - Latch master address, set end-of-line
// - Drive starts clock after enable sampled
// - Received parity lags; driven parity same clock
`timescale 1ns/10ps
`default_nettype none
module mpcd_top
   import mpcd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Controller commands (same clock domain)
   input wire logic [2:0] memory_cmd_code_i,
   input wire logic [3:0] pci_cmd_code_i,
   input wire logic pci_drive_enable_i,
   input wire logic trdy_b_i,
   // DRAM data bus
   input wire logic [63:0] mem_data_i,
   output logic [63:0] mem_data_o,
   output logic mem_data_oe_o,
   // PCI address/data
   input wire logic [31:0] pci_ad_i,
   output logic [31:0] pci_ad_o,
   output logic pci_ad_oe_o,
   output logic pci_parity_out_o,
   output logic end_of_line_flag_o,
   // Host side
   input wire logic [31:0] host_addr_i,
   input wire logic host_wr_valid_i,
   input wire logic [63:0] host_wr_data_i,
   output logic host_wr_ready_o,
   input wire logic cpw_push_i,
   input wire logic [31:0] cpw_addr_i,
   input wire logic [31:0] cpw_data_i,
   input wire logic [1:0] pf_rd_idx_i,
   output logic [31:0] pf_rd_data_o
);
   // Pin synchronisers for bus inputs
   logic [31:0] ad_s1_ff, ad_ff;
   logic [63:0] md_s1_ff, md_ff;
   logic trdy_s1_ff, trdy_b_ff;

   // Buffers
   logic [63:0] rd_buf_ff [RD_QWORDS];
   logic [1:0] rd_wp_ff;
   logic [2:0] rd_dp_ff;
   logic [31:0] pmw_addr_ff [2];
   logic [31:0] pmw_data_ff [2][PMW_DWORDS];
   logic pmw_wsel_ff, pmw_rsel_ff;
   logic [1:0] pmw_wp_ff, pmw_rp_ff;
   logic [2:0] pmw_cnt_ff [2];
   logic [31:0] cpw_addr_ff [CPW_ENTRIES];
   logic [31:0] cpw_data_ff [CPW_ENTRIES];
   logic [1:0] cpw_wp_ff, cpw_rp_ff;
   logic [31:0] cpw_last_ff;
   logic cpw_adv_ff;
   logic [31:0] pf_ff [PF_DWORDS];
   logic [1:0] pf_wp_ff;
   mpcd_pci_cmd_t prev_pc_ff;
   logic [31:0] maddr_ff;
   logic [3:0] eol_cnt_ff;
   logic [63:0] mem_lat_ff;
   logic [31:0] pci_out_ff;

   mpcd_mem_cmd_t mc;
   mpcd_pci_cmd_t pc;
   assign mc = mpcd_mem_cmd_t'(memory_cmd_code_i);
   assign pc = mpcd_pci_cmd_t'(pci_cmd_code_i);

   function automatic logic is_out_cmd(input mpcd_pci_cmd_t c);
      case (c)
         PC_SEND_HIGH, PC_SEND_LOW, PC_SEND_NEXT, PC_DRV_WADDR, PC_DRV_WDATA,
         PC_DRV_LAST, PC_DISCARD, PC_BACKUP, PC_SEND_HADDR: is_out_cmd = 1'b1;
         default: is_out_cmd = 1'b0;
      endcase
   endfunction

   function automatic logic is_eol_dec(input mpcd_pci_cmd_t c);
      case (c)
         PC_POST_ADDR, PC_POST_DATA, PC_SEND_HIGH, PC_SEND_LOW,
         PC_SEND_NEXT: is_eol_dec = 1'b1;
         default: is_eol_dec = 1'b0;
      endcase
   endfunction

   // Host posted-write path through the two-entry buffer
   wire hw_valid;
   wire [63:0] hw_data;
   wire hw_pop = (mc == MC_RETIRE_HOST);
   mpcd_skid u_skid (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(host_wr_valid_i),
      .in_ready_o(host_wr_ready_o),
      .in_data_i(host_wr_data_i),
      .out_valid_o(hw_valid),
      .out_ready_i(hw_pop),
      .out_data_o(hw_data)
   );

   // Memory-side selection
   wire [1:0] rd_slot = (mc == MC_FILL_FIRST) ? 2'h0 : rd_wp_ff;
   wire rd_fill = (mc == MC_FILL_FIRST) || (mc == MC_FILL_NEXT);
   wire [31:0] pmw_lo = pmw_data_ff[pmw_rsel_ff][pmw_rp_ff];
   wire [31:0] pmw_hi = pmw_data_ff[pmw_rsel_ff][pmw_rp_ff + 2'h1];
   wire [31:0] pmw_prev = (pmw_rp_ff == 2'h0) ? 32'h0 :
                          pmw_data_ff[pmw_rsel_ff][pmw_rp_ff - 2'h1];
   wire retire_pci = (mc == MC_RETIRE_PCI) || (mc == MC_RETIRE_SHIFT);
   // Shifted retire places dword n at position n+1
   wire [63:0] shift_q = {pmw_lo, pmw_prev};
   wire [63:0] pci_q = {pmw_hi, pmw_lo};
   wire [2:0] rp_next = {1'b0, pmw_rp_ff} + 3'h2;
   wire [2:0] pmw_cnt = pmw_cnt_ff[pmw_rsel_ff];
   // A shifted line spans one position more than its dword count; a full
   // four-dword shifted line ends at the buffer's edge and drops its tail
   wire pmw_done = (mc == MC_RETIRE_SHIFT) ? ((rp_next > pmw_cnt) || rp_next[2]) :
                   (rp_next >= pmw_cnt);
   wire mem_retire = hw_pop || retire_pci;
   wire [63:0] ret_data = hw_pop ? hw_data : (mc == MC_RETIRE_SHIFT) ? shift_q : pci_q;
   wire mem_drive = mem_retire || (mc == MC_HOLD_DRIVE);

   // PCI-side selection
   wire [63:0] rd_q = rd_buf_ff[rd_dp_ff[2:1]];
   wire [31:0] rd_dw = rd_dp_ff[0] ? rd_q[63:32] : rd_q[31:0];
   logic [31:0] pci_val;
   always_comb begin
      case (pc)
         PC_SEND_HIGH: pci_val = rd_buf_ff[0][63:32];
         PC_SEND_LOW: pci_val = rd_buf_ff[0][31:0];
         PC_SEND_NEXT: pci_val = rd_dw;
         PC_DRV_WADDR: pci_val = cpw_addr_ff[cpw_rp_ff];
         PC_DRV_WDATA: pci_val = cpw_data_ff[cpw_rp_ff];
         PC_DRV_LAST: pci_val = cpw_last_ff;
         PC_SEND_HADDR: pci_val = host_addr_i;
         default: pci_val = pci_out_ff;
      endcase
   end
   wire pf_adv = ((pc == PC_PF_TOG_A) && (prev_pc_ff == PC_PF_FIRST ||
                  prev_pc_ff == PC_PF_TOG_B)) ||
                 ((pc == PC_PF_TOG_B) && (prev_pc_ff == PC_PF_TOG_A));
   wire [1:0] pf_slot = (pc == PC_PF_FIRST) ? 2'h0 :
                        pf_adv ? pf_wp_ff + 2'h1 : pf_wp_ff;
   wire pf_wr = (pc == PC_PF_FIRST) || (pc == PC_PF_TOG_A) || (pc == PC_PF_TOG_B);
   wire [3:0] eol_base = (pc == PC_POST_ADDR) ? EOL_RST : eol_cnt_ff;
   wire [3:0] eol_left = LINE_DWORDS[3:0] - {1'b0, ad_ff[4:2]};

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ad_s1_ff <= DWORD_RST;
         ad_ff <= DWORD_RST;
         md_s1_ff <= QWORD_RST;
         md_ff <= QWORD_RST;
         trdy_s1_ff <= 1'b1;
         trdy_b_ff <= 1'b1;
      end else begin
         ad_s1_ff <= pci_ad_i;
         ad_ff <= ad_s1_ff;
         md_s1_ff <= mem_data_i;
         md_ff <= md_s1_ff;
         trdy_s1_ff <= trdy_b_i;
         trdy_b_ff <= trdy_s1_ff;
      end
   end

   // Memory command state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_wp_ff <= 2'h0;
         pmw_rsel_ff <= 1'b0;
         pmw_rp_ff <= 2'h0;
         mem_lat_ff <= QWORD_RST;
         mem_data_o <= QWORD_RST;
         mem_data_oe_o <= 1'b0;
      end else begin
         if (rd_fill) rd_wp_ff <= rd_slot + 2'h1;
         if (retire_pci) begin
            if (pmw_done) begin
               pmw_rsel_ff <= ~pmw_rsel_ff;
               pmw_rp_ff <= 2'h0;
            end else begin
               pmw_rp_ff <= rp_next[1:0];
            end
         end
         if (mem_retire) mem_lat_ff <= ret_data;
         mem_data_o <= mem_retire ? ret_data : mem_lat_ff;
         mem_data_oe_o <= mem_drive;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rd_fill) rd_buf_ff[rd_slot] <= md_ff;
      if (pf_wr) pf_ff[pf_slot] <= ad_ff;
      if (pc == PC_POST_DATA) pmw_data_ff[pmw_wsel_ff][pmw_wp_ff] <= ad_ff;
      if (pc == PC_POST_ADDR) pmw_addr_ff[~pmw_wsel_ff] <= maddr_ff;
      if (cpw_push_i) begin
         cpw_addr_ff[cpw_wp_ff] <= cpw_addr_i;
         cpw_data_ff[cpw_wp_ff] <= cpw_data_i;
      end
   end

   // PCI command state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // First post-address selects buffer zero, where retiring starts
         pmw_wsel_ff <= 1'b1;
         pmw_wp_ff <= 2'h0;
         pmw_cnt_ff <= '{3'h0, 3'h0};
         rd_dp_ff <= 3'h0;
         cpw_wp_ff <= 2'h0;
         cpw_rp_ff <= 2'h0;
         cpw_last_ff <= DWORD_RST;
         cpw_adv_ff <= 1'b0;
         pf_wp_ff <= 2'h0;
         prev_pc_ff <= PC_RSVD;
         maddr_ff <= DWORD_RST;
         eol_cnt_ff <= EOL_RST;
         end_of_line_flag_o <= 1'b0;
         pci_out_ff <= DWORD_RST;
         pci_ad_o <= DWORD_RST;
         pci_ad_oe_o <= 1'b0;
         pci_parity_out_o <= 1'b0;
         pf_rd_data_o <= DWORD_RST;
      end else begin
         prev_pc_ff <= pc;
         pf_rd_data_o <= pf_ff[pf_rd_idx_i];
         if (pf_wr) pf_wp_ff <= pf_slot;
         if (is_eol_dec(pc)) eol_cnt_ff <= eol_base - 4'h1;
         case (pc)
            PC_POST_ADDR: begin
               pmw_wsel_ff <= ~pmw_wsel_ff;
               pmw_wp_ff <= 2'h0;
               pmw_cnt_ff[~pmw_wsel_ff] <= 3'h0;
            end
            PC_POST_DATA: begin
               pmw_wp_ff <= pmw_wp_ff + 2'h1;
               pmw_cnt_ff[pmw_wsel_ff] <= {1'b0, pmw_wp_ff} + 3'h1;
            end
            PC_SEND_LOW: rd_dp_ff <= 3'h1;
            PC_SEND_HIGH: rd_dp_ff <= 3'h2;
            PC_SEND_NEXT: rd_dp_ff <= rd_dp_ff + 3'h1;
            PC_DRV_WDATA: cpw_last_ff <= cpw_data_ff[cpw_rp_ff];
            PC_DISCARD: cpw_rp_ff <= cpw_rp_ff + 2'h1;
            PC_BACKUP: cpw_rp_ff <= cpw_rp_ff - 2'h1;
            PC_LATCH_MADDR: begin
               maddr_ff <= ad_ff;
               eol_cnt_ff <= eol_left;
               end_of_line_flag_o <= (ad_ff[4:2] == 3'h7);
            end
            default: begin
            end
         endcase
         // TRDY sampled with drive-data advances on the following clock
         cpw_adv_ff <= (pc == PC_DRV_WDATA) && !trdy_b_ff;
         if (cpw_adv_ff && pc != PC_BACKUP && pc != PC_DISCARD)
            cpw_rp_ff <= cpw_rp_ff + 2'h1;
         if (cpw_push_i) cpw_wp_ff <= cpw_wp_ff + 2'h1;
         pci_out_ff <= pci_val;
         // Drive begins the clock after the enable is seen and drops the clock after it falls
         pci_ad_oe_o <= pci_drive_enable_i;
         pci_ad_o <= pci_val;
         // Output parity with the driven word, input parity one clock late
         pci_parity_out_o <= is_out_cmd(pc) ? ^pci_val : ^ad_ff;
      end
   end

   mem_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_IDLE || mc == MC_RSVD |=> !mem_data_oe_o)
      else $error("Memory bus driven after idle command");
   hold_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_HOLD_DRIVE |=> mem_data_oe_o && mem_data_o == $past(mem_lat_ff))
      else $error("Hold drive lost latched data");
   pci_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pci_ad_oe_o |-> $past(pci_drive_enable_i))
      else $error("PCI lines driven without enable");
   drive_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pci_drive_enable_i |=> pci_ad_oe_o)
      else $error("PCI drive did not start");
   eol_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_LATCH_MADDR |=> end_of_line_flag_o == ($past(ad_ff[4:2]) == 3'h7))
      else $error("End of line flag wrong");
   addr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_DRV_WADDR && !cpw_adv_ff && !cpw_push_i |=> $stable(cpw_rp_ff))
      else $error("Drive address moved pointer");
   backup_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_BACKUP |=> cpw_rp_ff == $past(cpw_rp_ff) - 2'h1)
      else $error("Backup did not step back");
   out_parity_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      is_out_cmd(pc) |=> pci_parity_out_o == ^pci_ad_o)
      else $error("Driven parity mismatch");
   post_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_POST_ADDR |=> pmw_wsel_ff != $past(pmw_wsel_ff) && pmw_wp_ff == 2'h0)
      else $error("Post address did not select new buffer");
   post_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_POST_ADDR |=> pmw_addr_ff[pmw_wsel_ff] == $past(maddr_ff) && eol_cnt_ff == EOL_RST - 4'h1)
      else $error("Post address did not load master address");
   eol_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      is_eol_dec(pc) && pc != PC_POST_ADDR |=> eol_cnt_ff == $past(eol_cnt_ff) - 4'h1)
      else $error("End of line count did not step down");
   fill_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_FILL_FIRST |=> rd_buf_ff[0] == $past(md_ff))
      else $error("Fill first did not store slot zero");
   pf_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_PF_FIRST |=> pf_wp_ff == 2'h0 && pf_ff[0] == $past(ad_ff))
      else $error("Latch first did not fill slot zero");
   discard_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_DISCARD |=> cpw_rp_ff == $past(cpw_rp_ff) + 2'h1)
      else $error("Discard did not drop entry");
   drive_last_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_DRV_LAST |=> pci_ad_o == $past(cpw_last_ff))
      else $error("Drive last did not repeat data");

   retire_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_RETIRE_PCI ##1 mc == MC_HOLD_DRIVE ##1 mc == MC_IDLE);
   toggle_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_PF_FIRST ##1 pc == PC_PF_TOG_A ##1 pc == PC_PF_TOG_B);
   wdata_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      pc == PC_DRV_WDATA && !trdy_b_ff ##1 pc == PC_DRV_LAST);
   host_retire_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_RETIRE_HOST && hw_valid);
   shift_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      mc == MC_RETIRE_SHIFT ##1 mc == MC_HOLD_DRIVE);
endmodule
`default_nettype wire
